// file: presettable_up_down_counter4_test.sv
module presettable_up_down_counter4_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clock = 0;
  logic i_arst_n = 0;
  logic psel = 0, pen = 0, pw = 0, prdy, perr, se, t = 0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0000_0000, prd, rd, seed = 32'h996f_1d5f;
  logic [3:0] m = 4'h0, e;
  int err_count = 0, n_checks = 0;
  int k;
  pudc_link link();
  pudc_counter u_pudc_counter(.i_clock(i_clock), .i_arst_n(i_arst_n),
    .link(link));
  pudc_ctrl u_pudc_ctrl(.i_clock(i_clock), .i_arst_n(i_arst_n),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pw), .i_paddr(pa),
    .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr),
    .link(link));
  pudc_asserts u_pudc_asserts(.i_clock(i_clock), .i_arst_n(i_arst_n),
    .count_enable_n(link.count_enable_n), .down(link.down),
    .load_n(link.load_n), .preset_data(link.preset_data),
    .count(link.count), .max_min(link.max_min),
    .ripple_carry_n(link.ripple_carry_n));
  always #10 i_clock = ~i_clock;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x)
    begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, s, x);
    end
  endtask
  // Entered right after a rising edge; leaves one idle edge behind it
  task automatic apb(input logic w, input logic [11:0] a, input int d);
    int n;
    n = 0;
    psel <= 1'b1;
    pw <= w;
    pa <= a;
    pwd <= d;
    @(posedge i_clock);
    pen <= 1'b1;
    do
    begin
      @(posedge i_clock);
      n++;
    end
    while (prdy !== 1'b1 && n < 40);
    rd = prd;
    se = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 40)
    begin
      err_count++;
      tally_and_finish();
    end
    @(posedge i_clock);
  endtask
  // Counts edges until load is seen low just after an edge
  task automatic wait_load(output int c);
    c = 0;
    do
    begin
      @(posedge i_clock);
      #1;
      c++;
    end
    while (link.load_n !== 1'b0 && c < 40);
    if (c >= 40)
    begin
      err_count++;
      tally_and_finish();
    end
  endtask
  // Reference count built from the level rules, checked after each edge
  always @(posedge i_clock)
  begin
    if (!i_arst_n)
      m = 4'h0;
    else if (!link.load_n)
      m = link.preset_data;
    else if (!link.count_enable_n)
      m = link.down ? m - 4'h1 : m + 4'h1;
    #1;
    e = link.load_n ? m : link.preset_data;
    t = e == (link.down ? 4'h0 : 4'hf);
    chk(link.count, e);
    chk(link.max_min, t);
  end
  always @(negedge i_clock)
  begin
    #1;
    chk(link.ripple_carry_n, !t);
  end
  initial
  begin
    repeat (6) @(posedge i_clock);
    i_arst_n <= 1'b1;
    @(posedge i_clock);
    apb(0, 12'h008, 0);
    chk(rd[5:0], 0);
    for (int i = 0; i < 8; i++)
    begin
      apb(1, 12'h004, i == 1 ? 15 : i == 3 ? 0 : rnd() & 32'h0000_000f);
      apb(1, 12'h000, 8);
      apb(1, 12'h000, i % 4);
      repeat (20) @(posedge i_clock);
      apb(1, 12'h000, 0);
      apb(0, 12'h008, 0);
      chk(rd[4:0], {t, m});
      chk(se, 0);
      apb(0, 12'h00c, 0);
      chk(se, 1);
    end
    // Auto reload from 13 counting up repeats every 17 - 13 edges
    apb(1, 12'h004, 13);
    apb(1, 12'h000, 8);
    apb(1, 12'h000, 5);
    wait_load(k);
    wait_load(k);
    chk(k, 4);
    @(posedge i_clock);
    apb(1, 12'h000, 0);
    apb(0, 12'h008, 0);
    chk(rd[5], 1);
    apb(1, 12'h008, 32);
    apb(0, 12'h008, 0);
    chk(rd[5], 0);
    tally_and_finish();
  end
endmodule // presettable_up_down_counter4_test

// file: pudc_asserts.sv
module pudc_asserts
(
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic count_enable_n,
  input wire logic down,
  input wire logic load_n,
  input wire logic [3:0] preset_data,
  input wire logic [3:0] count,
  input wire logic max_min,
  input wire logic ripple_carry_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  count_hold_a: assert property (
    load_n && count_enable_n ##1 load_n |-> $stable(count)) else $error("hold");
  count_up_a: assert property (
    load_n && !count_enable_n && !down ##1 load_n
    |-> count == $past(count) + 4'h1) else $error("up");
  count_down_a: assert property (
    load_n && !count_enable_n && down ##1 load_n
    |-> count == $past(count) - 4'h1) else $error("down");
  load_pass_a: assert property (!load_n |-> count == preset_data)
    else $error("preset");
  load_keep_a: assert property (
    !load_n ##1 load_n |-> count == $past(preset_data)) else $error("keep");
  terminal_flag_a: assert property (
    max_min == (count == (down ? 4'h0 : 4'hf))) else $error("maxmin");
  carry_low_a: assert property (ripple_carry_n == !max_min)
    else $error("carry");
  carry_idle_a: assert property (@(negedge i_clock) ripple_carry_n)
    else $error("carry high");
  cover property (max_min && !down);
  cover property (max_min && down);
  cover property (!load_n);
  cover property (!load_n && !count_enable_n);
endmodule // pudc_asserts

// file: pudc_counter.sv
module pudc_counter
(
  input wire logic i_clock,
  input wire logic i_arst_n,
  pudc_link.counter link
);
  logic [3:0] count;
  logic [3:0] next_count;
  logic [3:0] shown;
  logic terminal;

  always_comb
  begin
    next_count = count;
    if (!link.load_n)
    begin
      // Captured each edge while load is low, so the last value stays
      next_count = link.preset_data;
    end
    else if (!link.count_enable_n)
    begin
      if (link.down)
      begin
        next_count = count - 4'h1;
      end
      else
      begin
        next_count = count + 4'h1;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      count <= pudc_pkg::COUNT_RESET;
    end
    else
    begin
      count <= next_count;
    end
  end

  // Bypass gives the preset at the pins with no clock edge
  assign shown = link.load_n ? count : link.preset_data;
  assign terminal = link.down ? (shown == pudc_pkg::COUNT_MIN)
                              : (shown == pudc_pkg::COUNT_MAX);
  assign link.count = shown;
  assign link.max_min = terminal;
  // Clock level gating is intended: this output is a cascade clock
  assign link.ripple_carry_n = ~(terminal & ~i_clock);
endmodule // pudc_counter

// file: pudc_ctrl.sv
// The APB slave port and the placing of the registers are this design's own decisions.
module pudc_ctrl
(
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  pudc_link.control link
);
  logic [2:0] ctrl;
  logic [2:0] next_ctrl;
  logic [3:0] preset;
  logic [3:0] next_preset;
  logic load;
  logic next_load;
  logic terminal_seen;
  logic next_terminal_seen;
  logic [31:0] prdata;
  logic [31:0] next_prdata;
  logic pslverr;
  logic next_pslverr;
  logic access;
  logic mapped;

  assign access = i_psel & i_penable;
  assign mapped = (i_paddr == pudc_pkg::REG_CTRL)
                | (i_paddr == pudc_pkg::REG_PRESET)
                | (i_paddr == pudc_pkg::REG_STATUS);

  always_comb
  begin
    next_ctrl = ctrl;
    next_preset = preset;
    next_prdata = prdata;
    next_pslverr = 1'b0;
    next_load = 1'b0;
    // Auto reload: one load cycle after terminal count
    if (ctrl[pudc_pkg::CTRL_RELOAD_BIT] && ctrl[pudc_pkg::CTRL_ENABLE_BIT]
        && link.max_min && !load)
    begin
      next_load = 1'b1;
    end
    // Write-one-to-clear; a new terminal count in the same cycle wins
    next_terminal_seen = terminal_seen;
    if (access && i_pwrite && i_paddr == pudc_pkg::REG_STATUS
        && i_pwdata[pudc_pkg::STATUS_TERMINAL_BIT])
    begin
      next_terminal_seen = 1'b0;
    end
    if (link.max_min && ctrl[pudc_pkg::CTRL_ENABLE_BIT] && link.load_n)
    begin
      next_terminal_seen = 1'b1;
    end
    // Response is formed at the setup edge, so it stands through access
    if (i_psel && !i_penable)
    begin
      next_pslverr = ~mapped;
      if (!i_pwrite)
      begin
        next_prdata = 32'h0000_0000;
        if (i_paddr == pudc_pkg::REG_CTRL)
        begin
          next_prdata[2:0] = ctrl;
        end
        if (i_paddr == pudc_pkg::REG_PRESET)
        begin
          next_prdata[3:0] = preset;
        end
        if (i_paddr == pudc_pkg::REG_STATUS)
        begin
          next_prdata[3:0] = link.count;
          next_prdata[pudc_pkg::STATUS_MAX_MIN_BIT] = link.max_min;
          next_prdata[pudc_pkg::STATUS_TERMINAL_BIT] = terminal_seen;
        end
      end
    end
    if (access && i_pwrite)
    begin
      if (i_paddr == pudc_pkg::REG_CTRL)
      begin
        next_ctrl = i_pwdata[2:0];
        if (i_pwdata[pudc_pkg::CTRL_LOAD_BIT])
        begin
          next_load = 1'b1;
        end
      end
      if (i_paddr == pudc_pkg::REG_PRESET)
      begin
        next_preset = i_pwdata[3:0];
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      ctrl <= pudc_pkg::CTRL_RESET;
      preset <= pudc_pkg::PRESET_RESET;
      load <= 1'b0;
      terminal_seen <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      ctrl <= next_ctrl;
      preset <= next_preset;
      load <= next_load;
      terminal_seen <= next_terminal_seen;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // No wait states: the registered response already stands in access
  assign o_pready = access;
  assign o_prdata = prdata;
  assign o_pslverr = pslverr;
  assign link.count_enable_n = ~ctrl[pudc_pkg::CTRL_ENABLE_BIT];
  assign link.down = ctrl[pudc_pkg::CTRL_DOWN_BIT];
  assign link.load_n = ~load;
  assign link.preset_data = preset;
endmodule // pudc_ctrl

// file: pudc_link.sv
interface pudc_link;
  logic count_enable_n;
  logic down;
  logic load_n;
  logic [3:0] preset_data;
  logic [3:0] count;
  logic max_min;
  logic ripple_carry_n;

  modport counter
  (
    input count_enable_n,
    input down,
    input load_n,
    input preset_data,
    output count,
    output max_min,
    output ripple_carry_n
  );

  modport control
  (
    output count_enable_n,
    output down,
    output load_n,
    output preset_data,
    input count,
    input max_min,
    input ripple_carry_n
  );
endinterface

// file: pudc_pkg.sv
// Operation
// - Four-bit count, all bits clocked together
// - Count on rising edge only while enable low
// - Direction low counts up, high counts down
// - Count wraps modulo sixteen both ways
// - Control changes act only at next edge; here load, and direction at max/min, act at once
// - Load low presets count from data inputs
// - Preset reaches outputs without waiting for clock
// - Max/min high at terminal count for direction
// - Ripple carry low at terminal while clock low
// - Common clock: ripple carry feeds next enable
// - Common enable: ripple carry feeds next clock
// - Max/min may drive look-ahead carry logic
// - Reload preset to build modulo-N divider
package pudc_pkg;
  localparam int unsigned COUNT_WIDTH = 4;
  localparam logic [3:0] COUNT_MAX = 4'hf;
  localparam logic [3:0] COUNT_MIN = 4'h0;
  localparam logic [3:0] COUNT_RESET = 4'h00;

  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_PRESET = 12'h004;
  localparam logic [11:0] REG_STATUS = 12'h008;

  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned CTRL_DOWN_BIT = 1;
  localparam int unsigned CTRL_RELOAD_BIT = 2;
  localparam int unsigned CTRL_LOAD_BIT = 3;
  localparam int unsigned STATUS_MAX_MIN_BIT = 4;
  localparam int unsigned STATUS_TERMINAL_BIT = 5;

  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [3:0] PRESET_RESET = 4'h0;
endpackage
